// File: src/drive_fault_trip_supervisor.v
// fault supervisor: compares feedback to limits, latches trips and error codes
// Notes on behaviour
// - A safety option shutoff, internal or path fault cuts and trips with code 60 to 63.
// - A broken encoder wire cuts the output and trips with code 100.
// - A position beyond the forward range limit cuts the output and trips with code 104.
// - When the gap action is error (01), a speed gap above its limit trips with code 105.
// - Speed above the overspeed limit for the dwell time trips with code 107.
// - Assigned contactor feedback not following the drive in its window trips with code 110.
// - With soft start check on, feedback short of threshold in its window trips code 120.
// - Abnormal level tripping applies only for action trip (02) or trip after stop (03).
// - The watched value above range reports code 121, below range code 122.
// - With thermal decay off, resets are ignored for ten seconds after an overload trip.
// - With decay on, reset is accepted at once and the overload value keeps decaying.
// - The thermistor function may be assigned only to input slot five, never elsewhere.
// - The safety state monitor output is driven only while the monitor switch is set.
`timescale 1ns/1ps
`include "trip_supervisor_defines.vh"
module drive_fault_trip_supervisor #(
   parameter RESET_HOLD = `RESET_HOLD_CYCLES
) (
   // clock and reset
   input wire sys_clk,
   input wire reset_n,
   // wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output wire wb_ack_o,
   // feedback from the drive
   input wire [31:0] position_in,
   input wire [15:0] speed_ref_in,
   input wire [15:0] speed_fb_in,
   input wire [15:0] pid_fb_in,
   input wire [15:0] watch_value_0,
   input wire [15:0] watch_value_1,
   input wire [15:0] overload_value_in,
   // pins from the far side
   input wire [3:0] safe_torque_cut_fault,
   input wire encoder_broken,
   input wire contactor_feedback_in,
   input wire overload_trip,
   input wire run_start,
   input wire safety_state,
   input wire safety_monitor_switch,
   // outputs
   output reg drive_enable,
   output reg contactor_drive_out,
   output reg safety_monitor_out,
   output reg [7:0] error_code,
   output reg trip,
   output reg [15:0] overload_value,
   output wire irq
);

////////////////////////////////////////////////////////////////////////////////
function [31:0] ms_to_cycles;
   input [15:0] ms;
   begin
      ms_to_cycles = ms * `MS_CYCLES;
   end
endfunction

function [15:0] absdiff;
   input [15:0] a;
   input [15:0] b;
   begin
      absdiff = (a > b) ? a - b : b - a;
   end
endfunction

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers
reg [7:0] pin_meta_reg;
reg [7:0] pin_sync_reg;
always @(posedge sys_clk or negedge reset_n) begin
   if (!reset_n) begin
      pin_meta_reg <= 8'h00;
      pin_sync_reg <= 8'h00;
   end else begin
      pin_meta_reg <= {safety_monitor_switch, safety_state, overload_trip,
         contactor_feedback_in, encoder_broken, safe_torque_cut_fault[2:0]};
      pin_sync_reg <= pin_meta_reg;
   end
end
reg sto3_meta_reg;
reg sto3_sync_reg;
always @(posedge sys_clk or negedge reset_n) begin
   if (!reset_n) begin
      sto3_meta_reg <= 1'b0;
      sto3_sync_reg <= 1'b0;
   end else begin
      sto3_meta_reg <= safe_torque_cut_fault[3];
      sto3_sync_reg <= sto3_meta_reg;
   end
end
wire [3:0] sto_s = {sto3_sync_reg, pin_sync_reg[2:0]};
wire enc_s = pin_sync_reg[3];
wire cok_s = pin_sync_reg[4];
wire ovl_s = pin_sync_reg[5];
wire sst_s = pin_sync_reg[6];
wire msw_s = pin_sync_reg[7];

////////////////////////////////////////////////////////////////////////////////
// registers
reg [15:0] ctrl_reg;
reg [15:0] gap_limit_reg;
reg [15:0] os_limit_reg;
reg [15:0] os_dwell_reg;
reg [15:0] con_window_reg;
reg [15:0] ss_window_reg;
reg [15:0] ss_thresh_reg;
reg [15:0] up_limit_reg;
reg [15:0] lo_limit_reg;
reg [31:0] pos_limit_reg;
reg [7:0] event_reg;
reg [7:0] mask_reg;
reg [2:0] assign_reg;
reg ack_reg;
wire access = wb_cyc_i & wb_stb_i & ~ack_reg;
wire wr = access & wb_we_i & (&wb_sel_i);
wire rd_event = access & ~wb_we_i & (wb_adr_i == `REG_EVENT);
wire reset_req = wr & (wb_adr_i == `REG_CTRL) & wb_dat_i[`CTRL_RESET_REQ];
assign wb_ack_o = ack_reg;
assign irq = |(event_reg & mask_reg);

wire [1:0] gap_sel = ctrl_reg[`CTRL_SPEED_GAP_SEL_LSB +: 2];
wire ss_en = ctrl_reg[`CTRL_SOFT_START_EN];
wire [1:0] up_act = ctrl_reg[`CTRL_UPPER_ACT_LSB +: 2];
wire [1:0] lo_act = ctrl_reg[`CTRL_LOWER_ACT_LSB +: 2];
wire [1:0] decay_sel = ctrl_reg[`CTRL_DECAY_SEL_LSB +: 2];
wire con_en = ctrl_reg[`CTRL_CONTACTOR_FB_EN];
wire watch_sel = ctrl_reg[`CTRL_WATCH_TARGET_LSB];
wire [15:0] watch = watch_sel ? watch_value_1 : watch_value_0;

////////////////////////////////////////////////////////////////////////////////
// fault detection
reg [31:0] os_cnt_reg;
reg [31:0] con_cnt_reg;
reg [31:0] ss_cnt_reg;
reg ss_done_reg;
reg con_state_reg;
wire os_fault = (os_cnt_reg >= ms_to_cycles(os_dwell_reg)) & (speed_fb_in > os_limit_reg);
wire con_fault = con_en & (cok_s != contactor_drive_out) &
   (con_cnt_reg >= ms_to_cycles(con_window_reg));
wire ss_fault = ss_en & ~ss_done_reg & (ss_cnt_reg >= ms_to_cycles(ss_window_reg));
wire up_on = (up_act == `ACT_TRIP) | (up_act == `ACT_TRIP_DECEL);
wire lo_on = (lo_act == `ACT_TRIP) | (lo_act == `ACT_TRIP_DECEL);

reg [7:0] code_next;
reg fault_next;
always @* begin
   code_next = 8'h00;
   fault_next = 1'b1;
   if (|sto_s) begin
      code_next = `CODE_SAFETY_BASE + {6'h00, (sto_s[0] ? 2'h0 : sto_s[1] ? 2'h1 :
         sto_s[2] ? 2'h2 : 2'h3)};
   end else if (enc_s) begin
      code_next = `CODE_ENCODER;
   end else if ($signed(position_in) > $signed(pos_limit_reg)) begin
      code_next = `CODE_POSITION;
   end else if (gap_sel == `ACT_ERROR && absdiff(speed_ref_in, speed_fb_in) > gap_limit_reg) begin
      code_next = `CODE_SPEED_GAP;
   end else if (os_fault) begin
      code_next = `CODE_OVERSPEED;
   end else if (con_fault) begin
      code_next = `CODE_CONTACTOR;
   end else if (ss_fault) begin
      code_next = `CODE_SOFT_START;
   end else if (up_on && watch > up_limit_reg) begin
      code_next = `CODE_ABN_UPPER;
   end else if (lo_on && watch < lo_limit_reg) begin
      code_next = `CODE_ABN_LOWER;
   end else if (ovl_s) begin
      code_next = `CODE_OVERLOAD;
   end else begin
      fault_next = 1'b0;
   end
end

////////////////////////////////////////////////////////////////////////////////
// timers, trip latch and reset gate
reg [31:0] hold_cnt_reg;
wire reset_ok = (hold_cnt_reg == 32'h0);
always @(posedge sys_clk or negedge reset_n) begin
   if (!reset_n) begin
      os_cnt_reg <= 32'h0;
      con_cnt_reg <= 32'h0;
      ss_cnt_reg <= 32'h0;
      ss_done_reg <= 1'b0;
      con_state_reg <= 1'b0;
      hold_cnt_reg <= 32'h0;
      trip <= 1'b0;
      error_code <= 8'h00;
      drive_enable <= 1'b0;
      contactor_drive_out <= 1'b0;
      safety_monitor_out <= 1'b0;
      overload_value <= 16'h0000;
   end else begin
      os_cnt_reg <= (speed_fb_in > os_limit_reg) ? os_cnt_reg + 32'h1 : 32'h0;
      con_state_reg <= contactor_drive_out;
      if (con_state_reg != contactor_drive_out || cok_s == contactor_drive_out) begin
         con_cnt_reg <= 32'h0;
      end else begin
         con_cnt_reg <= con_cnt_reg + 32'h1;
      end
      if (run_start) begin
         ss_cnt_reg <= 32'h0;
         ss_done_reg <= 1'b0;
      end else if (pid_fb_in >= ss_thresh_reg) begin
         ss_done_reg <= 1'b1;
      end else if (!ss_done_reg) begin
         ss_cnt_reg <= ss_cnt_reg + 32'h1;
      end
      // overload value kept across reset, only decays when enabled
      if (decay_sel == `DECAY_OFF || overload_value_in > overload_value) begin
         overload_value <= overload_value_in;
      end else if (overload_value != 16'h0000) begin
         overload_value <= overload_value - 16'h1;
      end
      if (hold_cnt_reg != 32'h0) begin
         hold_cnt_reg <= hold_cnt_reg - 32'h1;
      end
      if (!trip && fault_next) begin
         trip <= 1'b1;
         error_code <= code_next;
         if (code_next == `CODE_OVERLOAD && decay_sel == `DECAY_OFF) begin
            hold_cnt_reg <= RESET_HOLD;
         end
      end else if (trip && reset_req && reset_ok) begin
         trip <= 1'b0;
         error_code <= 8'h00;
      end
      drive_enable <= ~trip & ~fault_next;
      contactor_drive_out <= run_start ? 1'b1 : (trip ? 1'b0 : contactor_drive_out);
      safety_monitor_out <= msw_s & sst_s;
   end
end

////////////////////////////////////////////////////////////////////////////////
// bus slave
always @(posedge sys_clk or negedge reset_n) begin
   if (!reset_n) begin
      ack_reg <= 1'b0;
      ctrl_reg <= `CTRL_RESET;
      gap_limit_reg <= 16'h0000;
      os_limit_reg <= 16'hFFFF;
      os_dwell_reg <= 16'h0000;
      con_window_reg <= 16'h0000;
      ss_window_reg <= 16'h0000;
      ss_thresh_reg <= 16'h0000;
      up_limit_reg <= 16'hFFFF;
      lo_limit_reg <= 16'h0000;
      pos_limit_reg <= 32'h7FFFFFFF;
      event_reg <= 8'h00;
      mask_reg <= 8'h00;
      assign_reg <= 3'h0;
      wb_dat_o <= 32'h0;
   end else begin
      ack_reg <= access;
      if (rd_event) begin
         event_reg <= {7'h00, !trip && fault_next}; // set wins over the read clear
      end else begin
         event_reg <= event_reg | {7'h00, !trip && fault_next};
      end
      if (wr) begin
         case (wb_adr_i)
            `REG_CTRL: ctrl_reg <= wb_dat_i[15:0] & 16'hF7FF;
            `REG_SPEED_GAP_LIMIT: gap_limit_reg <= wb_dat_i[15:0];
            `REG_OVERSPEED_LIMIT: os_limit_reg <= wb_dat_i[15:0];
            `REG_OVERSPEED_DWELL: os_dwell_reg <= wb_dat_i[15:0];
            `REG_CONTACTOR_WINDOW: con_window_reg <= wb_dat_i[15:0];
            `REG_SOFT_START_WINDOW: ss_window_reg <= wb_dat_i[15:0];
            `REG_SOFT_START_THRESHOLD: ss_thresh_reg <= wb_dat_i[15:0];
            `REG_ABN_UPPER_LIMIT: up_limit_reg <= wb_dat_i[15:0];
            `REG_ABN_LOWER_LIMIT: lo_limit_reg <= wb_dat_i[15:0];
            `REG_POS_FWD_LIMIT: pos_limit_reg <= wb_dat_i;
            `REG_MASK: mask_reg <= wb_dat_i[7:0];
            `REG_INPUT_ASSIGN: begin
               // thermistor function code 1 only accepted in slot five
               if (wb_dat_i[3] == 1'b0 || wb_dat_i[2:0] == `THERMISTOR_SLOT) begin
                  assign_reg <= wb_dat_i[3] ? wb_dat_i[2:0] : 3'h0;
               end
            end
            default: ;
         endcase
      end
      if (access && !wb_we_i) begin
         case (wb_adr_i)
            `REG_CTRL: wb_dat_o <= {16'h0, ctrl_reg};
            `REG_STATUS: wb_dat_o <= {16'h0, overload_value[7:0], 3'h0, safety_monitor_out,
               reset_ok, contactor_drive_out, drive_enable, trip};
            `REG_CODE: wb_dat_o <= {24'h0, error_code};
            `REG_SPEED_GAP_LIMIT: wb_dat_o <= {16'h0, gap_limit_reg};
            `REG_OVERSPEED_LIMIT: wb_dat_o <= {16'h0, os_limit_reg};
            `REG_OVERSPEED_DWELL: wb_dat_o <= {16'h0, os_dwell_reg};
            `REG_CONTACTOR_WINDOW: wb_dat_o <= {16'h0, con_window_reg};
            `REG_SOFT_START_WINDOW: wb_dat_o <= {16'h0, ss_window_reg};
            `REG_SOFT_START_THRESHOLD: wb_dat_o <= {16'h0, ss_thresh_reg};
            `REG_ABN_UPPER_LIMIT: wb_dat_o <= {16'h0, up_limit_reg};
            `REG_ABN_LOWER_LIMIT: wb_dat_o <= {16'h0, lo_limit_reg};
            `REG_POS_FWD_LIMIT: wb_dat_o <= pos_limit_reg;
            `REG_EVENT: wb_dat_o <= {24'h0, event_reg};
            `REG_MASK: wb_dat_o <= {24'h0, mask_reg};
            `REG_INPUT_ASSIGN: wb_dat_o <= {28'h0, assign_reg != 3'h0, assign_reg};
            default: wb_dat_o <= 32'h0;
         endcase
      end
   end
end

endmodule

// File: common/trip_supervisor_defines.vh
// constants for the drive fault trip supervisor
`ifndef TRIP_SUPERVISOR_DEFINES_VH
`define TRIP_SUPERVISOR_DEFINES_VH
`define CLK_MHZ 200
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_CODE 8'h08
`define REG_SPEED_GAP_LIMIT 8'h0C
`define REG_OVERSPEED_LIMIT 8'h10
`define REG_OVERSPEED_DWELL 8'h14
`define REG_CONTACTOR_WINDOW 8'h18
`define REG_SOFT_START_WINDOW 8'h1C
`define REG_SOFT_START_THRESHOLD 8'h20
`define REG_ABN_UPPER_LIMIT 8'h24
`define REG_ABN_LOWER_LIMIT 8'h28
`define REG_POS_FWD_LIMIT 8'h2C
`define REG_EVENT 8'h30
`define REG_MASK 8'h34
`define REG_INPUT_ASSIGN 8'h38
`define CTRL_SPEED_GAP_SEL_LSB 0
`define CTRL_SOFT_START_EN 2
`define CTRL_UPPER_ACT_LSB 4
`define CTRL_LOWER_ACT_LSB 6
`define CTRL_DECAY_SEL_LSB 8
`define CTRL_CONTACTOR_FB_EN 10
`define CTRL_RESET_REQ 11
`define CTRL_WATCH_TARGET_LSB 12
`define CTRL_RESET 16'h0000
`define ACT_ERROR 2'h1
`define ACT_TRIP 2'h2
`define ACT_TRIP_DECEL 2'h3
`define DECAY_OFF 2'h0
`define CODE_SAFETY_BASE 8'h3C
`define CODE_ENCODER 8'h64
`define CODE_POSITION 8'h68
`define CODE_SPEED_GAP 8'h69
`define CODE_OVERSPEED 8'h6B
`define CODE_CONTACTOR 8'h6E
`define CODE_SOFT_START 8'h78
`define CODE_ABN_UPPER 8'h79
`define CODE_ABN_LOWER 8'h7A
`define CODE_OVERLOAD 8'h27
`define THERMISTOR_SLOT 3'h4
`define RESET_HOLD_MS 10000
`define RESET_HOLD_CYCLES (`RESET_HOLD_MS * 1000 * `CLK_MHZ)
`define MS_CYCLES (1000 * `CLK_MHZ)
`endif

// File: verif/trip_far_side_model.sv
// far side: encoder, output contactor and safety option card
`timescale 1ns/1ps
module trip_far_side_model (
   // clock
   input logic sys_clk,
   // commands from the bench
   input logic enc_cut,
   input logic [3:0] sto_cmd,
   input logic fb_stuck,
   // pins
   input logic contactor_drive_out,
   output logic encoder_broken,
   output logic [3:0] safe_torque_cut_fault,
   output logic contactor_feedback_in
);
   logic [1:0] lag_reg = 2'h0;
   assign encoder_broken = enc_cut;
   assign safe_torque_cut_fault = sto_cmd;
   // contactor closes two cycles late, or stays open when stuck
   always @(posedge sys_clk) begin
      lag_reg <= {lag_reg[0], contactor_drive_out};
   end
   assign contactor_feedback_in = fb_stuck ? 1'b0 : lag_reg[1];
endmodule

// File: verif/trip_supervisor_sva.sv
// port assertions for the trip supervisor
`timescale 1ns/1ps
module trip_supervisor_sva (
   // clock and reset
   input logic sys_clk,
   input logic reset_n,
   // bus
   input logic wb_cyc_i,
   input logic wb_stb_i,
   input logic wb_ack_o,
   // far side pins
   input logic encoder_broken,
   input logic [3:0] safe_torque_cut_fault,
   input logic safety_monitor_switch,
   // outputs
   input logic safety_monitor_out,
   input logic drive_enable,
   input logic [7:0] error_code,
   input logic trip
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   sequence s_ack_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   sequence s_trip_seen;
      ##[1:4] trip;
   endsequence
   property p_ack;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> s_ack_pulse;
   endproperty
   a_ack: assert property (p_ack) else $error("ack not one cycle");
   property p_cut;
      trip |-> !drive_enable;
   endproperty
   a_cut: assert property (p_cut) else $error("output on during trip");
   property p_hold;
      trip && $past(trip) |-> $stable(error_code);
   endproperty
   a_hold: assert property (p_hold) else $error("code changed");
   property p_stays;
      trip && !wb_cyc_i && !$past(wb_cyc_i) |=> trip;
   endproperty
   a_stays: assert property (p_stays) else $error("trip lost");
   property p_code;
      trip |-> error_code != 8'h00;
   endproperty
   a_code: assert property (p_code) else $error("no code");
   property p_enc;
      $rose(encoder_broken) && !trip |-> s_trip_seen;
   endproperty
   a_enc: assert property (p_enc) else $error("encoder cut missed");
   property p_sto;
      $rose(|safe_torque_cut_fault) && !trip |->
         ##[1:4] (trip && error_code >= 8'h3C && error_code <= 8'h45);
   endproperty
   a_sto: assert property (p_sto) else $error("safety fault missed");
   property p_mon;
      !safety_monitor_switch [*5] |-> !safety_monitor_out;
   endproperty
   a_mon: assert property (p_mon) else $error("monitor driven");
endmodule

// File: verif/drive_fault_trip_supervisor_tb_top.sv
// self-checking bench for the trip supervisor
`timescale 1ns/1ps
`include "trip_supervisor_defines.vh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
$display("[FAIL] %0t %h %h", $time, a, b); end end
module drive_fault_trip_supervisor_tb_top;
   logic sys_clk = 1'b0, reset_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00, error_code;
   logic [3:0] wb_sel_i = 4'h0, sto_cmd = 4'h0, safe_torque_cut_fault;
   logic [31:0] wb_dat_i = 32'h0, position_in = 32'h0, seed = 32'h8B3D, wb_dat_o, rd;
   logic [15:0] speed_ref_in = 16'h0, speed_fb_in = 16'h0, pid_fb_in = 16'h0, overload_value;
   logic [15:0] watch_value_0 = 16'h1F4, watch_value_1 = 16'h1F4, overload_value_in = 16'h0;
   logic enc_cut = 1'b0, fb_stuck = 1'b0, overload_trip = 1'b0, run_start = 1'b0;
   logic safety_state = 1'b0, safety_monitor_switch = 1'b0, irq_en = 1'b0;
   logic encoder_broken, contactor_feedback_in, wb_ack_o, drive_enable, contactor_drive_out;
   logic safety_monitor_out, trip, irq;
   logic [7:0] exp_q[$];
   int err_total = 0, n_checks = 0, k;
   drive_fault_trip_supervisor #(.RESET_HOLD(100)) u_dut (.sys_clk, .reset_n, .wb_cyc_i,
      .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .position_in,
      .speed_ref_in, .speed_fb_in, .pid_fb_in, .watch_value_0, .watch_value_1,
      .overload_value_in, .safe_torque_cut_fault, .encoder_broken, .contactor_feedback_in,
      .overload_trip, .run_start, .safety_state, .safety_monitor_switch, .drive_enable,
      .contactor_drive_out, .safety_monitor_out, .error_code, .trip, .overload_value, .irq);
   trip_far_side_model u_far (.sys_clk, .enc_cut, .sto_cmd, .fb_stuck, .contactor_drive_out,
      .encoder_broken, .safe_torque_cut_fault, .contactor_feedback_in);
   initial begin
      forever #2.5 sys_clk = ~sys_clk;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic end_sim();
      if (err_total == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
      int n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= s;
      do begin
         @(posedge sys_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1) begin
         err_total++;
         end_sim();
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask
   task automatic rdr(input logic [7:0] a);
      bus(1'b0, a, 32'h0, 4'hF);
   endtask
   // arm a check, start a run, then expect the latched trip and its code
   task automatic fault(input logic [31:0] ctl, input logic [7:0] code);
      exp_q.push_back(code);
      wr(`REG_CTRL, ctl);
      run_start <= 1'b1;
      tick(1);
      run_start <= 1'b0;
      for (k = 0; k < 40 && trip !== 1'b1; k++) tick(1);
      tick(4);
      `CHK(error_code, exp_q[0])
      `CHK(drive_enable, 1'b0)
      `CHK(contactor_drive_out, 1'b0)
      `CHK(irq, irq_en)
      rdr(`REG_CODE);
      `CHK(rd[7:0], exp_q.pop_front())
      rdr(`REG_EVENT);
      `CHK(rd[0], 1'b1)
      tick(1);
      `CHK(irq, 1'b0)
   endtask
   task automatic clr(input logic [31:0] ctl);
      tick(4);
      wr(`REG_CTRL, ctl | 32'h800);
      tick(2);
      `CHK(trip, 1'b0)
   endtask
   initial begin
      repeat (8) @(posedge sys_clk);
      reset_n <= 1'b1;
      tick(1);
      rdr(`REG_CTRL);
      `CHK(rd[15:0], `CTRL_RESET)
      rdr(8'h3C);
      `CHK(rd, 32'h0)
      bus(1'b1, `REG_MASK, 32'h1, 4'h1);
      rdr(`REG_MASK);
      `CHK(rd[0], 1'b0)
      k = rnd() % 4;
      sto_cmd[k] <= 1'b1;
      fault(32'h0, 8'h3C + k[7:0]);
      sto_cmd <= 4'h0;
      clr(32'h0);
      wr(`REG_MASK, 32'h1);
      irq_en = 1'b1;
      enc_cut <= 1'b1;
      fault(32'h0, `CODE_ENCODER);
      enc_cut <= 1'b0;
      clr(32'h0);
      wr(`REG_POS_FWD_LIMIT, 32'h100);
      position_in <= 32'h101 + (rnd() % 32'h40);
      fault(32'h0, `CODE_POSITION);
      position_in <= 32'h0;
      clr(32'h0);
      wr(`REG_SPEED_GAP_LIMIT, 32'hA);
      wr(`REG_ABN_UPPER_LIMIT, 32'h3E8);
      wr(`REG_ABN_LOWER_LIMIT, 32'h64);
      speed_ref_in <= 16'h64;
      speed_fb_in <= 16'h32;
      watch_value_0 <= 16'h7D0;
      wr(`REG_CTRL, 32'h12);
      tick(20);
      `CHK(trip, 1'b0)
      fault(32'h1, `CODE_SPEED_GAP);
      speed_ref_in <= 16'h0;
      speed_fb_in <= 16'h0;
      watch_value_0 <= 16'h1F4;
      watch_value_1 <= 16'h7D0;
      clr(32'h0);
      fault(32'h1020, `CODE_ABN_UPPER);
      watch_value_1 <= 16'h1F4;
      watch_value_0 <= 16'h32;
      clr(32'h0);
      fault(32'hC0, `CODE_ABN_LOWER);
      watch_value_0 <= 16'h1F4;
      clr(32'h0);
      wr(`REG_OVERSPEED_LIMIT, 32'hC8);
      wr(`REG_OVERSPEED_DWELL, 32'h0);
      speed_fb_in <= 16'h12C;
      fault(32'h0, `CODE_OVERSPEED);
      speed_fb_in <= 16'h0;
      clr(32'h0);
      fb_stuck <= 1'b1;
      wr(`REG_CONTACTOR_WINDOW, 32'h0);
      fault(32'h400, `CODE_CONTACTOR);
      fb_stuck <= 1'b0;
      clr(32'h0);
      wr(`REG_SOFT_START_THRESHOLD, 32'h1F4);
      wr(`REG_SOFT_START_WINDOW, 32'h0);
      fault(32'h4, `CODE_SOFT_START);
      clr(32'h0);
      overload_trip <= 1'b1;
      fault(32'h0, `CODE_OVERLOAD);
      overload_trip <= 1'b0;
      tick(4);
      wr(`REG_CTRL, 32'h800);
      `CHK(trip, 1'b1)
      tick(100);
      clr(32'h0);
      overload_value_in <= 16'h32;
      overload_trip <= 1'b1;
      fault(32'h100, `CODE_OVERLOAD);
      overload_value_in <= 16'h0;
      overload_trip <= 1'b0;
      clr(32'h100);
      `CHK(overload_value > 16'h0, 1'b1)
      wr(`REG_INPUT_ASSIGN, 32'h9);
      rdr(`REG_INPUT_ASSIGN);
      `CHK(rd[3:0], 4'h0)
      wr(`REG_INPUT_ASSIGN, 32'hC);
      rdr(`REG_INPUT_ASSIGN);
      `CHK(rd[3:0], 4'hC)
      safety_state <= 1'b1;
      tick(6);
      `CHK(safety_monitor_out, 1'b0)
      safety_monitor_switch <= 1'b1;
      tick(6);
      `CHK(safety_monitor_out, 1'b1)
      end_sim();
   end
   // the sequence takes about 500 cycles; allow thirty times that
   initial begin
      #75000;
      err_total++;
      end_sim();
   end
endmodule
bind drive_fault_trip_supervisor trip_supervisor_sva u_sva (.sys_clk, .reset_n, .wb_cyc_i,
   .wb_stb_i, .wb_ack_o, .encoder_broken, .safe_torque_cut_fault, .safety_monitor_switch,
   .safety_monitor_out, .drive_enable, .error_code, .trip);
